// ---- rtl/umc_consts.vh ----
// constants for the usb module control block
`ifndef UMC_CONSTS_VH
`define UMC_CONSTS_VH
`define UMC_ADDR_CTRL      4'h0
`define UMC_ADDR_CFG       4'h4
`define UMC_CTRL_PPRST     6
`define UMC_CTRL_SE0       5
`define UMC_CTRL_PACKET_PROCESSING_DISABLE    4
`define UMC_CTRL_EN        3
`define UMC_CTRL_RESUME    2
`define UMC_CTRL_SUSP      1
`define UMC_CFG_EYE        7
`define UMC_CFG_OEMON      6
`define UMC_CFG_PUEN       4
`define UMC_CFG_TRDIS      3
`define UMC_CFG_FS         2
`define UMC_CFG_PPB_HI     1
`define UMC_CFG_PPB_LO     0
`define UMC_CTRL_RESET     8'h00
`define UMC_CFG_RESET      8'h00
`define UMC_CTRL_WMASK     8'h4E
`define UMC_CFG_WMASK      8'hDF
`define UMC_RESP_OKAY      2'h0
`define UMC_RESP_SLVERR    2'h2
`define UMC_RESUME_MS      10
`endif

// ---- rtl/umc_sync.v ----
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module umc_sync #(
    parameter W = 2
) (
    input  wire         core_clk,   // system clock
    input  wire         nrst,       // async reset, active low
    input  wire [W-1:0] d,          // asynchronous levels
    output reg  [W-1:0] q           // synchronised levels
);
    reg [W-1:0] meta_r;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/umc_ctrl.v ----
// usb module control and configuration registers over axi4-lite
`timescale 1ns/10ps
`default_nettype none
`include "umc_consts.vh"
module umc_ctrl (
    input  wire        core_clk,          // 50 MHz clock
    input  wire        nrst,              // async reset, active low
    input  wire [3:0]  s_axi_awaddr,      // write address
    input  wire        s_axi_awvalid,     // write address valid
    output reg         s_axi_awready,     // write address ready
    input  wire [31:0] s_axi_wdata,       // write data
    input  wire [3:0]  s_axi_wstrb,       // write strobes
    input  wire        s_axi_wvalid,      // write data valid
    output reg         s_axi_wready,      // write data ready
    output reg  [1:0]  s_axi_bresp,       // write response
    output reg         s_axi_bvalid,      // write response valid
    input  wire        s_axi_bready,      // write response ready
    input  wire [3:0]  s_axi_araddr,      // read address
    input  wire        s_axi_arvalid,     // read address valid
    output reg         s_axi_arready,     // read address ready
    output reg  [31:0] s_axi_rdata,       // read data
    output reg  [1:0]  s_axi_rresp,       // read response
    output reg         s_axi_rvalid,      // read data valid
    input  wire        s_axi_rready,      // read data ready
    input  wire        bus_vp,            // d+ single-ended receiver pin
    input  wire        bus_vm,            // d- single-ended receiver pin
    input  wire        setup_token_rx,    // engine pulse: setup token seen
    output reg         module_active,     // module and circuitry enabled
    output reg         regulator_on,      // regulator enable request
    output reg         pingpong_clear,    // clear every pointer bit
    output reg         pingpong_force_even, // hold pointers on even bank
    output reg         engine_halt,       // token and packet processing halted
    output reg         resume_drive,      // drive resume signalling
    output reg         engine_clk_en,     // engine input clock gate
    output reg         low_power,         // module in power conserve mode
    output reg         xcvr_idle,         // transceiver outputs forced idle
    output reg         xcvr_external,     // external transceiver selected
    output reg         full_speed,        // full-speed edge rates
    output reg         pullup_on,         // on-chip pull-up enable
    output reg         oe_monitor,        // output enable monitor on
    output reg         eye_test,          // eye pattern test on
    output reg  [1:0]  pingpong_mode      // ping-pong buffering mode
);
    reg [7:0] ctrl_r;
    reg [7:0] cfg_r;
    reg       se0_r;
    reg       aw_got_r;
    reg [3:0] aw_addr_r;
    reg       w_got_r;
    reg [7:0] w_data_r;
    reg       w_strb_r;
    wire [1:0] pins_s;
    wire       se0_now;
    wire       en;
    wire       susp;
    wire       pp_mode_on;
    wire       wr_go;
    wire       rd_go;
    wire [1:0] wr_sel;
    wire [1:0] rd_sel;
    wire       ctrl_wr;
    wire       cfg_wr;
    reg [7:0]  ctrl_nxt;
    reg [7:0]  cfg_nxt;
    reg [7:0]  rd_byte;
    reg [1:0]  rd_resp;
    reg        module_active_nxt;
    reg        regulator_on_nxt;
    reg        pingpong_clear_nxt;
    reg        pingpong_force_even_nxt;
    reg        engine_halt_nxt;
    reg        resume_drive_nxt;
    reg        engine_clk_en_nxt;
    reg        low_power_nxt;
    reg        xcvr_idle_nxt;
    reg        xcvr_external_nxt;
    reg        full_speed_nxt;
    reg        pullup_on_nxt;
    reg        oe_monitor_nxt;
    reg        eye_test_nxt;
    reg [1:0]  pingpong_mode_nxt;

    localparam SEL_CTRL = 2'h0;
    localparam SEL_CFG  = 2'h1;
    localparam SEL_NONE = 2'h3;

    // flag applies only when the module is enabled
    function gated;
        input e;
        input b;
        begin
            gated = e & b;
        end
    endfunction

    // which register an address selects; anything else is refused
    function [1:0] reg_sel;
        input [3:0] a;
        begin
            if (a == `UMC_ADDR_CTRL) begin
                reg_sel = SEL_CTRL;
            end else if (a == `UMC_ADDR_CFG) begin
                reg_sel = SEL_CFG;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    umc_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .d        ({bus_vp, bus_vm}),
        .q        (pins_s)
    );

    assign en         = ctrl_r[`UMC_CTRL_EN];
    assign susp       = ctrl_r[`UMC_CTRL_SUSP];
    // live bus state, shown whether or not enabled
    assign se0_now    = ~pins_s[1] & ~pins_s[0];
    // pointer reset only means something with ping-pong buffers
    assign pp_mode_on = cfg_r[`UMC_CFG_PPB_HI:`UMC_CFG_PPB_LO] != 2'h0;
    assign wr_go      = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign rd_go      = s_axi_arvalid & s_axi_arready;
    assign wr_sel     = reg_sel(aw_addr_r);
    assign rd_sel     = reg_sel(s_axi_araddr);
    // byte lane 0 carries the whole register
    assign ctrl_wr    = wr_go & w_strb_r & (wr_sel == SEL_CTRL);
    assign cfg_wr     = wr_go & w_strb_r & (wr_sel == SEL_CFG);

    // single-ended zero: both lines low
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            se0_r <= 1'b0;
        end else begin
            se0_r <= se0_now;
        end
    end

    // write channel capture, either order
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_got_r      <= 1'b0;
            aw_addr_r     <= 4'h0;
            w_got_r       <= 1'b0;
            w_data_r      <= 8'h00;
            w_strb_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `UMC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_got_r & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_got_r & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_sel != SEL_NONE) begin
                    s_axi_bresp <= `UMC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `UMC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // next control value; reachable in suspend too
    always @* begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            ctrl_nxt = w_data_r & `UMC_CTRL_WMASK;
            // packet disable: firmware may clear only
            ctrl_nxt[`UMC_CTRL_PACKET_PROCESSING_DISABLE] = ctrl_r[`UMC_CTRL_PACKET_PROCESSING_DISABLE] & w_data_r[`UMC_CTRL_PACKET_PROCESSING_DISABLE];
        end
        // set wins over a simultaneous clear
        if (setup_token_rx & en) begin
            ctrl_nxt[`UMC_CTRL_PACKET_PROCESSING_DISABLE] = 1'b1;
        end
    end

    // next configuration value
    always @* begin
        cfg_nxt = cfg_r;
        if (cfg_wr) begin
            cfg_nxt = w_data_r & `UMC_CFG_WMASK;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `UMC_CTRL_RESET;
            cfg_r  <= `UMC_CFG_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r  <= cfg_nxt;
        end
    end

    // read channel
    always @* begin
        rd_byte = 8'h00;
        rd_resp = `UMC_RESP_OKAY;
        if (rd_sel == SEL_CTRL) begin
            rd_byte = ctrl_r & `UMC_CTRL_WMASK | {2'b00, se0_r, ctrl_r[`UMC_CTRL_PACKET_PROCESSING_DISABLE], 4'h0};
        end else if (rd_sel == SEL_CFG) begin
            rd_byte = cfg_r;
        end else begin
            rd_resp = `UMC_RESP_SLVERR;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `UMC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~s_axi_arvalid ? 1'b0 :
                             ~s_axi_arready & ~s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_resp;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // next levels toward engine, transceiver and regulator
    always @* begin
        module_active_nxt       = en;
        regulator_on_nxt        = en & ~susp;
        pingpong_clear_nxt      = en & ~module_active;
        // only in a ping-pong mode, only when enabled
        pingpong_force_even_nxt = gated(en, ctrl_r[`UMC_CTRL_PPRST]) & pp_mode_on;
        // pending status fifo is untouched by this halt
        engine_halt_nxt         = gated(en, ctrl_r[`UMC_CTRL_PACKET_PROCESSING_DISABLE]);
        resume_drive_nxt        = gated(en, ctrl_r[`UMC_CTRL_RESUME]) & ~susp;
        engine_clk_en_nxt       = en & ~susp;
        low_power_nxt           = ~en | susp;
        // suspend keeps the outputs idle even with resume set
        xcvr_idle_nxt           = ~en | susp;
        xcvr_external_nxt       = cfg_r[`UMC_CFG_TRDIS];
        full_speed_nxt          = cfg_r[`UMC_CFG_FS];
        pullup_on_nxt           = gated(en, cfg_r[`UMC_CFG_PUEN]) & ~cfg_r[`UMC_CFG_TRDIS];
        oe_monitor_nxt          = cfg_r[`UMC_CFG_OEMON] | cfg_r[`UMC_CFG_TRDIS];
        eye_test_nxt            = gated(en, cfg_r[`UMC_CFG_EYE]);
        pingpong_mode_nxt       = cfg_r[`UMC_CFG_PPB_HI:`UMC_CFG_PPB_LO];
    end

    // outputs toward engine, transceiver and regulator
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            module_active       <= 1'b0;
            regulator_on        <= 1'b0;
            pingpong_clear      <= 1'b0;
            pingpong_force_even <= 1'b0;
            engine_halt         <= 1'b0;
            resume_drive        <= 1'b0;
            engine_clk_en       <= 1'b0;
            low_power           <= 1'b0;
            xcvr_idle           <= 1'b1;
            xcvr_external       <= 1'b0;
            full_speed          <= 1'b0;
            pullup_on           <= 1'b0;
            oe_monitor          <= 1'b0;
            eye_test            <= 1'b0;
            pingpong_mode       <= 2'h0;
        end else begin
            module_active       <= module_active_nxt;
            regulator_on        <= regulator_on_nxt;
            pingpong_clear      <= pingpong_clear_nxt;
            pingpong_force_even <= pingpong_force_even_nxt;
            engine_halt         <= engine_halt_nxt;
            resume_drive        <= resume_drive_nxt;
            engine_clk_en       <= engine_clk_en_nxt;
            low_power           <= low_power_nxt;
            xcvr_idle           <= xcvr_idle_nxt;
            xcvr_external       <= xcvr_external_nxt;
            full_speed          <= full_speed_nxt;
            pullup_on           <= pullup_on_nxt;
            oe_monitor          <= oe_monitor_nxt;
            eye_test            <= eye_test_nxt;
            pingpong_mode       <= pingpong_mode_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- tb/umc_host_model.sv ----
// host side model: bus line levels and setup token events
`timescale 1ns/10ps
`default_nettype none
module umc_host_model (
    input  wire logic core_clk,       // clock
    output var  logic bus_vp,         // d+ level
    output var  logic bus_vm,         // d- level
    output var  logic setup_token_rx  // setup token seen
);
    initial begin
        bus_vp = 1'b1;
        bus_vm = 1'b0;
        setup_token_rx = 1'b0;
    end
    // idle j state when not in se0
    task drive_se0(input logic on);
        @(posedge core_clk);
        bus_vp <= ~on;
        bus_vm <= 1'b0;
    endtask
    task send_setup();
        @(posedge core_clk);
        setup_token_rx <= 1'b1;
        @(posedge core_clk);
        setup_token_rx <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/umc_ctrl_asserts.sv ----
// assertions on the control block outputs
`timescale 1ns/10ps
`default_nettype none
module umc_ctrl_asserts (
    input wire logic       core_clk,            // clock
    input wire logic       nrst,                // reset
    input wire logic       s_axi_arvalid,       // ar valid
    input wire logic       s_axi_arready,       // ar ready
    input wire logic       s_axi_rvalid,        // r valid
    input wire logic       setup_token_rx,      // setup token
    input wire logic       module_active,       // enabled
    input wire logic       pingpong_clear,      // pointer clear
    input wire logic       pingpong_force_even, // even bank
    input wire logic       engine_halt,         // halted
    input wire logic       resume_drive,        // resume
    input wire logic       engine_clk_en,       // clock gate
    input wire logic       low_power,           // low power
    input wire logic       xcvr_idle,           // idle outputs
    input wire logic       xcvr_external,       // ext xcvr
    input wire logic       pullup_on,           // pull-up
    input wire logic [1:0] pingpong_mode        // pp mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence token_on;
        module_active && setup_token_rx;
    endsequence
    halt_needs_en_a: assert property (engine_halt |-> module_active) else $error("halt while off");
    clk_gate_a: assert property (engine_clk_en |-> module_active && !low_power) else $error("gate");
    ptr_clear_a: assert property ($rose(module_active) |-> ##[0:1] pingpong_clear) else $error("clr");
    even_bank_a: assert property (pingpong_force_even |-> pingpong_mode != 2'h0) else $error("even");
    pullup_int_a: assert property (pullup_on |-> !xcvr_external) else $error("pull-up");
    resume_out_a: assert property (resume_drive |-> !xcvr_idle && engine_clk_en) else $error("resume");
    susp_idle_a: assert property (module_active && !engine_clk_en |-> xcvr_idle) else $error("idle");
    token_halt_a: assert property (token_on |-> ##[1:3] engine_halt) else $error("token");
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid) else $error("read");
endmodule
bind umc_ctrl umc_ctrl_asserts i_umc_ctrl_asserts (.core_clk, .nrst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .setup_token_rx, .module_active, .pingpong_clear, .pingpong_force_even, .engine_halt,
    .resume_drive, .engine_clk_en, .low_power, .xcvr_idle, .xcvr_external, .pullup_on, .pingpong_mode);
`default_nettype wire

// ---- tb/umc_ctrl_tb_top.sv ----
// self-checking bench for the usb module control block
`timescale 1ns/10ps
`default_nettype none
module umc_ctrl_tb_top;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, pingpong_mode;
    wire  [31:0] s_axi_rdata;
    wire         bus_vp, bus_vm, setup_token_rx, module_active, regulator_on, pingpong_clear;
    wire         pingpong_force_even, engine_halt, resume_drive, engine_clk_en, low_power;
    wire         xcvr_idle, xcvr_external, full_speed, pullup_on, oe_monitor, eye_test;
    int          num_errors = 0, checked = 0, cycles = 0;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp, wr_resp;
    umc_ctrl i_umc_ctrl (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .bus_vp, .bus_vm, .setup_token_rx, .module_active, .regulator_on, .pingpong_clear,
        .pingpong_force_even, .engine_halt, .resume_drive, .engine_clk_en, .low_power, .xcvr_idle,
        .xcvr_external, .full_speed, .pullup_on, .oe_monitor, .eye_test, .pingpong_mode);
    umc_host_model i_umc_host_model (.core_clk, .bus_vp, .bus_vm, .setup_token_rx);
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task print_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write, then let outputs settle
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task t_reset_values();
        rd(4'h0);
        chk(rd_data, 32'h0);
        rd(4'h4);
        chk(rd_data, 32'h0);
        chk(xcvr_external, 32'h0);
    endtask
    task t_enable();
        wr(4'h4, 8'h11);
        wr(4'h0, 8'hD9);
        rd(4'h0);
        chk(rd_data, 32'h48);
        chk({regulator_on, engine_clk_en, engine_halt}, 32'h6);
        chk(pingpong_force_even, 32'h1);
        chk(pullup_on, 32'h1);
        chk({oe_monitor, pingpong_mode}, 32'h1);
    endtask
    task t_setup();
        i_umc_host_model.send_setup();
        repeat (3) @(posedge core_clk);
        rd(4'h0);
        chk(rd_data, 32'h58);
        chk(engine_halt, 32'h1);
        wr(4'h0, 8'h48);
        rd(4'h0);
        chk(rd_data, 32'h48);
        chk(engine_halt, 32'h0);
    endtask
    task t_config();
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h1C); // configured while detached
        wr(4'h0, 8'h48);
        chk(pullup_on, 32'h0);
        chk(xcvr_external, 32'h1);
        chk(full_speed, 32'h1);
        chk(oe_monitor, 32'h1);
        chk(pingpong_force_even, 32'h0);
    endtask
    task t_se0();
        i_umc_host_model.drive_se0(1'b1);
        repeat (4) @(posedge core_clk);
        rd(4'h0);
        chk(rd_data, 32'h68);
        i_umc_host_model.drive_se0(1'b0);
        repeat (4) @(posedge core_clk);
        rd(4'h0);
        chk(rd_data, 32'h48);
    endtask
    task t_suspend();
        wr(4'h0, 8'h0A); // bus idle assumed seen
        chk({engine_clk_en, low_power, regulator_on}, 32'h2);
        chk({module_active, xcvr_idle}, 32'h3);
        rd(4'h0);
        chk(rd_data, 32'h0A);
        wr(4'h0, 8'h0C);
        chk(resume_drive, 32'h1);
        wr(4'h0, 8'h0E);
        chk({resume_drive, xcvr_idle}, 32'h1);
        wr(4'h0, 8'h08);
        chk(resume_drive, 32'h0);
    endtask
    task t_disabled();
        wr(4'h4, 8'h81);
        wr(4'h0, 8'h40);
        chk({pingpong_force_even, module_active, xcvr_idle, eye_test}, 32'h2);
        i_umc_host_model.send_setup();
        repeat (3) @(posedge core_clk);
        rd(4'h0);
        chk(rd_data, 32'h40);
        s_axi_wstrb <= 4'hE;
        wr(4'h0, 8'h48);
        chk(wr_resp, 32'h0);
        s_axi_wstrb <= 4'hF;
        wr(4'h8, 8'h48);
        chk(wr_resp, 32'h2);
        rd(4'h0);
        chk(rd_data, 32'h40);
        rd(4'h8);
        chk({rd_resp, rd_data[29:0]}, 32'h80000000);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_values();
        t_enable();
        t_setup();
        t_config();
        t_se0();
        t_suspend();
        t_disabled();
        print_verdict();
    end
endmodule
`default_nettype wire
